// ---- hw/mprds_cfg.svh ----
// constants for the mii port role and direction select block
// assumes inclusion once per compile unit via guard
//
// Function
// - col sampled from phy in mac mode, driven to mac in phy mode
// - crs input from phy in mac mode, driven as carrier in phy mode
// - tx clock supplied by phy in mac mode, generated and driven in phy mode
// - rx clock supplied by phy in mac mode, generated and driven in phy mode
// - receive nibbles flow phy to switch in mac mode, switch to mac in phy mode
// - rx data valid qualifies nibbles; input in mac mode, output in phy mode
// - mdio exchanged with external master as slave, with external phy as master
// - mdc input from master as slave, driven to phy as master
// - port duplex follows the duplex pin live while autoneg enable is set
// - autoneg enable cleared: ignore duplex pin, use programmed duplex
// - polarity strap 0: pin 0 full duplex; strap 1: pin 1 full duplex
// - receive error output held low in phy mode
// - transmit error output held low in mac mode
// - transmit error from external mac in phy mode aborts current receive packet
`ifndef MPRDS_CFG_SVH
`define MPRDS_CFG_SVH

// ************************************************************
// timing
// ************************************************************
`define MPRDS_CLK_PERIOD_PS    5000
`define MPRDS_MII_CLK_PERIOD_NS 40
// half period of the generated 25 MHz mii clock in system cycles
`define MPRDS_MII_HALF_CYC     ((`MPRDS_MII_CLK_PERIOD_NS * 1000) / (2 * `MPRDS_CLK_PERIOD_PS))
`define MPRDS_MDC_PERIOD_NS    400
`define MPRDS_MDC_HALF_CYC     ((`MPRDS_MDC_PERIOD_NS * 1000) / (2 * `MPRDS_CLK_PERIOD_PS))
`define MPRDS_DIV_W            6

// ************************************************************
// field values and reset values
// ************************************************************
`define MPRDS_DUPLEX_FULL      1'b1
`define MPRDS_RST_DUPLEX       1'b0

`endif

// ---- hw/mprds_clk_if.sv ----
// carrier for generated clocks between top and divider
// assumes one clock domain, clk_sys
`timescale 1ns/1ps
interface mprds_clk_if;
    logic run;
    logic tick;
    logic level;
    modport gen (input run, output tick, output level);
    modport use_side (output run, input tick, input level);
endinterface

// ---- hw/mprds_clkgen.sv ----
// square-wave clock divider off clk_sys
// assumes half period of at least one cycle
`timescale 1ns/1ps
`include "mprds_cfg.svh"
module mprds_clkgen #(
    parameter logic [`MPRDS_DIV_W-1:0] HALF = `MPRDS_DIV_W'(1)
) (
    // system
    input  wire logic     clk_sys,
    input  wire logic     rst,
    // carrier
    mprds_clk_if.gen      cg
);
    import mprds_pkg::*;

    typedef struct packed {
        logic [`MPRDS_DIV_W-1:0] cnt;
        logic                    lvl;
    } mprds_div_t;

    mprds_div_t s_reg;
    mprds_div_t s_next;

    // count up to the half period, toggle on wrap; stopped clock rests low
    always_comb begin
        s_next = s_reg;
        if (!cg.run) begin
            s_next.cnt = '0;
            s_next.lvl = 1'b0;
        end else if (s_reg.cnt == HALF - 1'b1) begin
            s_next.cnt = '0;
            s_next.lvl = ~s_reg.lvl;
        end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cg.level = s_reg.lvl;
    assign cg.tick  = cg.run && (s_reg.cnt == HALF - 1'b1) && s_reg.lvl;

    AST_DIV_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst)
        (cg.run && $past(cg.run) && s_reg.cnt == HALF - 1'b1) |=> (s_reg.lvl != $past(s_reg.lvl)))
        else $error("divider did not toggle at half period");
endmodule

// ---- hw/mprds_pkg.sv ----
// types shared by the mii port role and direction select block
// assumes the cfg header is compiled alongside
package mprds_pkg;
    // port role: mac faces an external phy, phy faces an external mac
    typedef enum logic {
        MPRDS_ROLE_MAC = 1'b0,
        MPRDS_ROLE_PHY = 1'b1
    } mprds_role_t;

    // management role
    typedef enum logic {
        MPRDS_MGMT_SLAVE  = 1'b0,
        MPRDS_MGMT_MASTER = 1'b1
    } mprds_mgmt_t;

    // receive frame tracker states, gray along idle-run-drop
    typedef enum logic [1:0] {
        MPRDS_RX_IDLE = 2'b00,
        MPRDS_RX_RUN  = 2'b01,
        MPRDS_RX_DROP = 2'b11
    } mprds_rxst_t;
endpackage

// ---- hw/mprds_top.sv ----
// mii port 0 role and direction select with duplex derivation
// assumes pins resolved by the bench from out/oe; rx clock is a plain sampled input, tx clock input is unused
`timescale 1ns/1ps
`include "mprds_cfg.svh"
module mprds_top (
    // system
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // role configuration
    input  wire mprds_pkg::mprds_role_t port_role,
    input  wire mprds_pkg::mprds_mgmt_t mgmt_role,
    input  wire logic                  duplex_pol_strap,
    input  wire logic                  virtual_phy_autoneg_enable,
    input  wire logic                  virtual_phy_duplex,
    // duplex pin and result
    input  wire logic                  duplex_pin,
    output logic                       port_full_duplex,
    // collision pin
    input  wire logic                  col_in,
    output logic                       col_out,
    output logic                       col_oe,
    // carrier sense pin
    input  wire logic                  crs_in,
    output logic                       crs_out,
    output logic                       crs_oe,
    // transmit clock pin
    input  wire logic                  txclk_in,
    output logic                       txclk_out,
    output logic                       txclk_oe,
    // receive clock pin
    input  wire logic                  rxclk_in,
    output logic                       rxclk_out,
    output logic                       rxclk_oe,
    // receive data and valid pins
    input  wire logic [3:0]            rxd_in,
    output logic [3:0]                 rxd_out,
    output logic                       rxd_oe,
    input  wire logic                  rxdv_in,
    output logic                       rxdv_out,
    output logic                       rxdv_oe,
    // error pins
    input  wire logic                  rxer_in,
    output logic                       rxer_out,
    output logic                       rxer_oe,
    input  wire logic                  txer_in,
    output logic                       txer_out,
    output logic                       txer_oe,
    // management pins
    input  wire logic                  mdio_in,
    output logic                       mdio_out,
    output logic                       mdio_oe,
    input  wire logic                  mdc_in,
    output logic                       mdc_out,
    output logic                       mdc_oe,
    // switch side, pins toward fabric
    output logic                       sw_col,
    output logic                       sw_crs,
    output logic [3:0]                 sw_rx_data,
    output logic                       sw_rx_valid,
    output logic                       sw_rx_abort,
    output logic                       sw_mii_clk_edge,
    // switch side, data toward pins in phy mode
    input  wire logic                  sw_col_drive,
    input  wire logic                  sw_crs_drive,
    input  wire logic [3:0]            sw_rx_data_drive,
    input  wire logic                  sw_rx_valid_drive,
    input  wire logic                  sw_txer_drive,
    // management engine side
    input  wire logic                  mgmt_mdio_out,
    input  wire logic                  mgmt_mdio_oe,
    input  wire logic                  mgmt_mdc_run,
    output logic                       mgmt_mdio_in,
    output logic                       mgmt_mdc_edge
);
    import mprds_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [11:0] s1;      // first synchroniser stage, read only by s2
        logic [11:0] s2;
        logic        rxclk_d;
        logic        mdc_d;
        mprds_rxst_t rxst;
        logic        fdx;
        logic        col;
        logic        crs;
        logic [3:0]  rxd;
        logic        rxdv;
        logic        abort;
        logic        clk_edge;
        logic        mdc_edge;
        logic [7:0]  drv;     // pin data: mdio, rxd, rxdv, col, crs
    } mprds_st_t;

    mprds_st_t st_reg;
    mprds_st_t st_next;

    // indices into the synchroniser vector
    localparam int I_COL = 0;
    localparam int I_CRS = 1;
    localparam int I_RXD = 2;
    localparam int I_DV  = 6;
    localparam int I_TXER = 7;
    localparam int I_RCK = 8;
    localparam int I_MDC = 9;
    localparam int I_DPX = 10;
    localparam int I_MDIO = 11;

    wire logic is_phy = (port_role == MPRDS_ROLE_PHY);
    wire logic is_mst = (mgmt_role == MPRDS_MGMT_MASTER);

    // rising edge of a synchronised level
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    // ************************************************************
    // generated clocks
    // ************************************************************
    mprds_clk_if mii_cg();
    mprds_clk_if mdc_cg();

    assign mii_cg.run = is_phy;
    assign mdc_cg.run = is_mst & mgmt_mdc_run;

    mprds_clkgen #(.HALF(`MPRDS_DIV_W'(`MPRDS_MII_HALF_CYC))) u_miiclk (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cg      (mii_cg)
    );
    mprds_clkgen #(.HALF(`MPRDS_DIV_W'(`MPRDS_MDC_HALF_CYC))) u_mdcclk (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cg      (mdc_cg)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.s1 = {mdio_in, duplex_pin, mdc_in, rxclk_in, txer_in, rxdv_in, rxd_in, crs_in, col_in};
        st_next.s2 = st_reg.s1;
        st_next.rxclk_d = st_reg.s2[I_RCK];
        st_next.mdc_d = st_reg.s2[I_MDC];
        // pin data leaves through flops so the pins never show decode glitches
        st_next.drv[7]   = mgmt_mdio_out;
        st_next.drv[6:0] = is_phy ? {sw_rx_data_drive, sw_rx_valid_drive, sw_col_drive, sw_crs_drive} : 7'h00;
        // duplex: live pin with polarity, or programmed value when autoneg off
        if (!virtual_phy_autoneg_enable) begin
            st_next.fdx = virtual_phy_duplex;
        end else begin
            st_next.fdx = (st_reg.s2[I_DPX] == duplex_pol_strap);
        end
        // mac mode samples rxd and rxdv on the received clock rising edge; col and crs every cycle
        st_next.clk_edge = is_phy ? mii_cg.tick : rise(st_reg.s2[I_RCK], st_reg.rxclk_d);
        st_next.mdc_edge = is_mst ? mdc_cg.tick : rise(st_reg.s2[I_MDC], st_reg.mdc_d);
        if (!is_phy) begin
            st_next.col = st_reg.s2[I_COL];
            st_next.crs = st_reg.s2[I_CRS];
            if (st_next.clk_edge) begin
                st_next.rxd  = st_reg.s2[I_RXD +: 4];
                st_next.rxdv = st_reg.s2[I_DV];
            end
        end else begin
            st_next.col = 1'b0;
            st_next.crs = 1'b0;
            st_next.rxd = 4'h0;
            st_next.rxdv = 1'b0;
        end
        // abort tracker: txer from external mac kills the current packet
        st_next.abort = 1'b0;
        case (st_reg.rxst)
            MPRDS_RX_IDLE: begin
                if (is_phy && sw_rx_valid_drive) begin
                    st_next.rxst = MPRDS_RX_RUN;
                end
            end
            MPRDS_RX_RUN: begin
                if (!is_phy || !sw_rx_valid_drive) begin
                    st_next.rxst = MPRDS_RX_IDLE;
                end else if (st_reg.s2[I_TXER]) begin
                    st_next.rxst  = MPRDS_RX_DROP;
                    st_next.abort = 1'b1;
                end
            end
            MPRDS_RX_DROP: begin
                if (!is_phy || !sw_rx_valid_drive) begin
                    st_next.rxst = MPRDS_RX_IDLE;
                end
            end
            default: begin
                st_next.rxst = MPRDS_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    // outputs only in the role that owns them; inputs left undriven
    assign col_oe    = is_phy;
    assign col_out   = st_reg.drv[1];
    assign crs_oe    = is_phy;
    assign crs_out   = st_reg.drv[0];
    assign txclk_oe  = is_phy;
    assign txclk_out = mii_cg.level;
    assign rxclk_oe  = is_phy;
    assign rxclk_out = mii_cg.level;
    assign rxd_oe    = is_phy;
    assign rxd_out   = st_reg.drv[6:3];
    assign rxdv_oe   = is_phy;
    assign rxdv_out  = st_reg.drv[2];
    assign rxer_oe   = is_phy;
    assign rxer_out  = 1'b0;
    assign txer_oe   = ~is_phy;
    assign txer_out  = 1'b0;
    // mdio is open-drain-like: engine chooses when to drive
    assign mdio_oe   = mgmt_mdio_oe;
    assign mdio_out  = st_reg.drv[7];
    assign mdc_oe    = is_mst;
    assign mdc_out   = mdc_cg.level;

    // switch-side outputs, all registered
    assign sw_col          = st_reg.col;
    assign sw_crs          = st_reg.crs;
    assign sw_rx_data      = st_reg.rxd;
    assign sw_rx_valid     = st_reg.rxdv;
    assign sw_rx_abort     = st_reg.abort;
    assign sw_mii_clk_edge = st_reg.clk_edge;
    assign mgmt_mdio_in    = st_reg.s2[I_MDIO];
    assign mgmt_mdc_edge   = st_reg.mdc_edge;
    assign port_full_duplex = st_reg.fdx;

    // ************************************************************
    // checks
    // ************************************************************
    AST_COL_DIR:   assert property (@(posedge clk_sys) disable iff (rst)
        !is_phy |-> !col_oe && !crs_oe) else $error("col or crs driven in mac mode");
    AST_CRS_FOLLOW: assert property (@(posedge clk_sys) disable iff (rst)
        (!is_phy && $stable(port_role)) ##1 !is_phy |-> sw_crs == $past(st_reg.s2[I_CRS]))
        else $error("carrier not followed");
    AST_CLK_OE:    assert property (@(posedge clk_sys) disable iff (rst)
        txclk_oe == is_phy && rxclk_oe == is_phy) else $error("clock enable wrong");
    AST_RXCLK_RUN: assert property (@(posedge clk_sys) disable iff (rst)
        (is_phy [*8]) ##1 is_phy |-> $changed(rxclk_out) || $past(rxclk_out, 2) != rxclk_out
        || $past(rxclk_out, 3) != rxclk_out || $past(rxclk_out, 4) != rxclk_out)
        else $error("rx clock not running in phy mode");
    AST_RXD_DIR:   assert property (@(posedge clk_sys) disable iff (rst)
        is_phy ##1 is_phy |-> rxd_oe && rxdv_oe && rxd_out == $past(sw_rx_data_drive))
        else $error("rxd not driven");
    AST_DV_QUAL:   assert property (@(posedge clk_sys) disable iff (rst)
        is_phy ##1 is_phy |-> !sw_rx_valid) else $error("valid seen in phy mode");
    AST_MDC_DIR:   assert property (@(posedge clk_sys) disable iff (rst)
        mdc_oe == is_mst) else $error("mdc direction wrong");
    AST_DPX_OVR:   assert property (@(posedge clk_sys) disable iff (rst)
        !virtual_phy_autoneg_enable |=> port_full_duplex == $past(virtual_phy_duplex))
        else $error("duplex override ignored");
    AST_DPX_POL:   assert property (@(posedge clk_sys) disable iff (rst)
        virtual_phy_autoneg_enable |=> port_full_duplex == ($past(st_reg.s2[I_DPX]) == $past(duplex_pol_strap)))
        else $error("duplex polarity wrong");
    AST_ERR_LOW:   assert property (@(posedge clk_sys) disable iff (rst)
        !rxer_out && !txer_out && (txer_oe != rxer_oe)) else $error("error pin not low");
    AST_ABORT:     assert property (@(posedge clk_sys) disable iff (rst)
        (st_reg.rxst == MPRDS_RX_RUN && is_phy && sw_rx_valid_drive && st_reg.s2[I_TXER]) |=> sw_rx_abort ##1 !sw_rx_abort)
        else $error("abort not pulsed");

    COV_PHY_ABORT: cover property (@(posedge clk_sys) disable iff (rst) sw_rx_abort);
    COV_MAC_DATA:  cover property (@(posedge clk_sys) disable iff (rst) !is_phy && sw_rx_valid);
    COV_MDC_GEN:   cover property (@(posedge clk_sys) disable iff (rst) is_mst && mgmt_mdc_edge);
    COV_DPX_FLIP:  cover property (@(posedge clk_sys) disable iff (rst) $changed(port_full_duplex));
endmodule

// ---- tb/mprds_partner.sv ----
// far party on mii port 0: a phy when the device is a mac, a mac when it is a phy
// assumes the bench resolves every partner-driven pin from both enables and the pin's pull level
`timescale 1ns/1ps
module mprds_partner (
    // role of the device
    input  wire mprds_pkg::mprds_role_t role,
    // phy side drive
    output logic                        clk_mii,
    output logic                        col,
    output logic                        crs,
    output logic [3:0]                  rxd,
    output logic                        rxdv,
    output logic                        phy_oe,
    // mac side drive
    output logic                        txer,
    output logic                        mac_oe
);
    import mprds_pkg::*;
    // ************************************************************
    // link clock and drive enables
    // ************************************************************
    // free running, like a real phy clock, 80 ns period
    initial begin
        clk_mii = 1'b0;
        forever #40 clk_mii = ~clk_mii;
    end
    // drives only toward a device that listens, else the pins fall to their pulls
    assign phy_oe = (role == MPRDS_ROLE_MAC);
    assign mac_oe = (role == MPRDS_ROLE_PHY);
    // quiet line levels at start
    initial begin
        col = 1'b0;
        crs = 1'b0;
        rxd = 4'h0;
        rxdv = 1'b0;
        txer = 1'b0;
    end
    // one nibble per clock, changed on the fall so it is settled at the rise
    task automatic send(input logic [3:0] nib);
        @(negedge clk_mii);
        rxd = nib;
        rxdv = 1'b1;
    endtask
    // end of frame: data inverted so a stale nibble never passes for a match
    task automatic idle();
        @(negedge clk_mii);
        rxdv = 1'b0;
        rxd = ~rxd;
    endtask
endmodule

// ---- tb/test_mprds_top.sv ----
// self-checking bench for the mii port role and direction select block
// assumes the partner model; pins are resolved here from enables and pull levels
`timescale 1ns/1ps
module test_mprds_top;
    import mprds_pkg::*;
    // ************************************************************
    // signals and pin resolution
    // ************************************************************
    logic        clk_sys, rst, duplex_pol_strap, virtual_phy_autoneg_enable, virtual_phy_duplex, duplex_pin;
    mprds_role_t port_role;
    mprds_mgmt_t mgmt_role;
    logic        port_full_duplex, col_out, col_oe, crs_out, crs_oe, txclk_out, txclk_oe, rxclk_out, rxclk_oe;
    logic [3:0]  rxd_out, sw_rx_data, sw_rx_data_drive, p_rxd;
    logic        rxd_oe, rxdv_out, rxdv_oe, rxer_out, rxer_oe, txer_out, txer_oe, mdio_out, mdio_oe, mdc_out, mdc_oe;
    logic        sw_col, sw_crs, sw_rx_valid, sw_rx_abort, sw_mii_clk_edge, mgmt_mdio_in, mgmt_mdc_edge;
    logic        sw_col_drive, sw_crs_drive, sw_rx_valid_drive, mgmt_mdio_out, mgmt_mdio_oe, mgmt_mdc_run;
    logic        p_clk, p_col, p_crs, p_rxdv, p_txer, p_phy_oe, p_mac_oe, ext_mdc;
    int          mismatches, checks;
    // released pins fall to their pull: col and mdio up, mdc to the outside master's ext_mdc, the rest down
    wire         col_in = col_oe ? col_out : (p_phy_oe ? p_col : 1'b1);
    wire         crs_in = crs_oe ? crs_out : (p_phy_oe & p_crs);
    wire         txclk_in = txclk_oe ? txclk_out : (p_phy_oe & p_clk);
    wire         rxclk_in = rxclk_oe ? rxclk_out : (p_phy_oe & p_clk);
    wire [3:0]   rxd_in = rxd_oe ? rxd_out : (p_phy_oe ? p_rxd : 4'h0);
    wire         rxdv_in = rxdv_oe ? rxdv_out : (p_phy_oe & p_rxdv);
    wire         rxer_in = rxer_oe & rxer_out;
    wire         txer_in = txer_oe ? txer_out : (p_mac_oe & p_txer);
    wire         mdio_in = mdio_oe ? mdio_out : 1'b1;
    wire         mdc_in = mdc_oe ? mdc_out : ext_mdc;
    wire         sw_txer_drive = 1'b0;

    mprds_top dut (.clk_sys, .rst, .port_role, .mgmt_role, .duplex_pol_strap, .virtual_phy_autoneg_enable,
        .virtual_phy_duplex, .duplex_pin, .port_full_duplex, .col_in, .col_out, .col_oe, .crs_in, .crs_out,
        .crs_oe, .txclk_in, .txclk_out, .txclk_oe, .rxclk_in, .rxclk_out, .rxclk_oe, .rxd_in, .rxd_out, .rxd_oe,
        .rxdv_in, .rxdv_out, .rxdv_oe, .rxer_in, .rxer_out, .rxer_oe, .txer_in, .txer_out, .txer_oe, .mdio_in,
        .mdio_out, .mdio_oe, .mdc_in, .mdc_out, .mdc_oe, .sw_col, .sw_crs, .sw_rx_data, .sw_rx_valid,
        .sw_rx_abort, .sw_mii_clk_edge, .sw_col_drive, .sw_crs_drive, .sw_rx_data_drive, .sw_rx_valid_drive,
        .sw_txer_drive, .mgmt_mdio_out, .mgmt_mdio_oe, .mgmt_mdc_run, .mgmt_mdio_in, .mgmt_mdc_edge);
    mprds_partner mdl (.role(port_role), .clk_mii(p_clk), .col(p_col), .crs(p_crs), .rxd(p_rxd),
        .rxdv(p_rxdv), .phy_oe(p_phy_oe), .txer(p_txer), .mac_oe(p_mac_oe));

    // ************************************************************
    // clock, helpers and expectations
    // ************************************************************
    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // inputs set after a step move 1 ns after the rising edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait; a miss shows up in the comparison that follows
    task automatic wait_hi(ref logic s, input int lim);
        while (s !== 1'b1 && lim > 0) begin
            step();
            lim--;
        end
    endtask
    task automatic count_edges(ref logic s, input int n, output int c);
        logic last;
        c = 0;
        last = s;
        repeat (n) begin
            step();
            if (s !== last) c++;
            last = s;
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // phy role drives the partner-facing pins, mac role only the transmit error
    function automatic logic [8:0] exp_oe(logic r, logic m);
        return {r, r, r, r, r, r, r, ~r, m};
    endfunction
    function automatic logic exp_full(logic an, logic pol, logic pin, logic vd);
        return an ? (pin == pol) : vd;
    endfunction
    // hang guard, far beyond the several hundred cycles the tests need
    initial begin
        #100us;
        mismatches++;
        summarize();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        logic [8:0] v;
        int c;
        mismatches = 0;
        checks = 0;
        void'($urandom(95));
        rst = 1'b1;
        {port_role, mgmt_role, duplex_pol_strap, virtual_phy_autoneg_enable, virtual_phy_duplex} = 5'h04;
        {duplex_pin, sw_col_drive, sw_crs_drive, sw_rx_data_drive, sw_rx_valid_drive} = 9'h100;
        {ext_mdc, mgmt_mdio_out, mgmt_mdio_oe, mgmt_mdc_run} = 4'h0;
        step(12);
        rst = 1'b0;
        // every role pair sets its own direction pattern
        for (int i = 0; i < 4; i++) begin
            port_role = mprds_role_t'(i[0]);
            mgmt_role = mprds_mgmt_t'(i[1]);
            step();
            chk("oe", exp_oe(i[0], i[1]), {col_oe, crs_oe, txclk_oe, rxclk_oe, rxd_oe, rxdv_oe, rxer_oe, txer_oe, mdc_oe});
            chk("err", 9'h0, {7'h0, rxer_out, txer_out});
        end
        // mac role: collision and carrier come in from the phy
        port_role = MPRDS_ROLE_MAC;
        for (int i = 0; i < 6; i++) begin
            v = 9'($urandom);
            mdl.col = v[0];
            mdl.crs = v[1];
            step(5);
            chk("col crs", {7'h0, v[1:0]}, {7'h0, sw_crs, sw_col});
        end
        // one frame of nibbles on the phy's clock, ending on the all-ones corner
        for (int i = 0; i < 8; i++) begin
            v = (i == 7) ? 9'h00f : 9'($urandom);
            mdl.send(v[3:0]);
            wait_hi(sw_mii_clk_edge, 40);
            chk("rx nibble", {4'h0, 1'b1, v[3:0]}, {4'h0, sw_rx_valid, sw_rx_data});
        end
        mdl.idle();
        wait_hi(sw_mii_clk_edge, 40);
        chk("rx idle", 9'h0, {8'h0, sw_rx_valid});
        // phy role: the switch drives the pins, pin levels are not taken in
        port_role = MPRDS_ROLE_PHY;
        for (int i = 0; i < 6; i++) begin
            v = 9'($urandom);
            {sw_rx_data_drive, sw_rx_valid_drive, sw_col_drive, sw_crs_drive} = v[6:0];
            step(3);
            chk("phy drive", {2'h0, v[6:0]}, {2'h0, rxd_out, rxdv_out, col_out, crs_out});
            chk("phy ignore", 9'h0, {6'h0, sw_col, sw_crs, sw_rx_valid});
        end
        // generated clocks: 8 cycle period gives 20 changes in 80 cycles
        count_edges(txclk_out, 80, c);
        chk("tx clock", 9'd20, 9'(c));
        count_edges(rxclk_out, 80, c);
        chk("rx clock", 9'd20, 9'(c));
        // transmit error from the mac in mid-packet
        sw_rx_valid_drive = 1'b0;
        step(2);
        sw_rx_valid_drive = 1'b1;
        step(2);
        mdl.txer = 1'b1;
        wait_hi(sw_rx_abort, 10);
        chk("abort", 9'h1, {8'h0, sw_rx_abort});
        mdl.txer = 1'b0;
        sw_rx_valid_drive = 1'b0;
        // duplex: all pin and polarity corners first, then random
        for (int i = 0; i < 16; i++) begin
            v = (i < 4) ? 9'(i + 4) : 9'($urandom);
            {virtual_phy_duplex, virtual_phy_autoneg_enable, duplex_pol_strap, duplex_pin} = v[3:0];
            step(5);
            chk("duplex", {8'h0, exp_full(v[2], v[1], v[0], v[3])}, {8'h0, port_full_duplex});
        end
        // management master: 80 cycle clock gives 4 changes in 160 cycles
        mgmt_role = MPRDS_MGMT_MASTER;
        mgmt_mdc_run = 1'b1;
        step(4);
        count_edges(mdc_out, 160, c);
        chk("mdc", 9'd4, 9'(c));
        // one engine pulse per generated period: 4 changes in 160 cycles
        count_edges(mgmt_mdc_edge, 160, c);
        chk("mdc edge", 9'd4, 9'(c));
        for (int i = 0; i < 3; i++) begin
            {mgmt_mdio_oe, mgmt_mdio_out} = i[1:0] ^ 2'h2;
            step(3);
            chk("mdio", {7'h0, mgmt_mdio_oe, mgmt_mdio_oe ? mgmt_mdio_out : 1'b1}, {7'h0, mdio_oe, mgmt_mdio_in});
        end
        // slave: a rise from an outside master reaches the engine as one pulse
        mgmt_role = MPRDS_MGMT_SLAVE;
        step(4);
        ext_mdc = 1'b1;
        wait_hi(mgmt_mdc_edge, 10);
        chk("mdc in", 9'h1, {8'h0, mgmt_mdc_edge});
        summarize();
    end
endmodule
